// ===== lcp_batt_model.sv
`timescale 1ns/100ps
module lcp_batt_model (
    // Commanded cell and source state
    input  wire logic [15:0] cmd_vbat,
    input  wire logic [15:0] cmd_system_rail,
    input  wire logic [15:0] cmd_vin,
    input  wire logic [7:0]  cmd_die,
    input  wire logic [6:0]  cmd_taper,
    // Charge loop from the block
    input  wire logic        cv_regulate,
    input  wire logic [6:0]  charge_current_set_pct,
    // Measurements back to the block
    output logic      [15:0] vbat_mv,
    output logic      [15:0] system_rail_mv,
    output logic      [15:0] input_supply_mv,
    output logic      [7:0]  die_temp_c,
    output logic      [6:0]  charge_current_pct
);
    assign vbat_mv         = cmd_vbat;
    assign system_rail_mv  = cmd_system_rail;
    assign input_supply_mv = cmd_vin;
    assign die_temp_c      = cmd_die;
    // Under CV the cell takes less than asked, so the taper is commanded
    assign charge_current_pct = cv_regulate ? cmd_taper : charge_current_set_pct;
endmodule // lcp_batt_model

// ===== lcp_charge_ctrl.sv
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "lcp_consts.svh"
// Function
// - Auto-enable above battery plus 100mV, gated
// - Below trickle threshold apply trickle current only; the code moves to trickle only on entry or from precondition
// - Trickle threshold codes 2.0/2.2/2.4/2.5V
// - Trickle current select 10mA or 25mA
// - Above trickle threshold enter precondition
// - Precondition threshold 2.7V plus 50mV steps
// - Precondition current 5..20% of fast
// - Above precondition threshold go fast charge
// - At termination voltage switch to CV
// - Termination voltage 3.9V plus 20mV steps
// - CV current below termination ends charge
// - Termination current 5..20% of fast
// - End of charge delivers zero current
// - Below recharge level resume fast charge
// - Input voltage threshold select, disable allowed
// - Input droop folds back; 3.8V supplement
// - Supplement mode: battery feeds system rail
// - Input current limit 0.5A to 2A
// - Die foldback 115C linear to 150C
// - 155C: interrupt, temperature status, fault
// - Thermal foldback disable bit
// - Thermistor flags: presence and temperature zone
module lcp_charge_ctrl (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    // Register port
    input  wire logic [3:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // Digitised analog measurements, asynchronous
    input  wire logic [15:0]          vbat_mv,
    input  wire logic [15:0]          system_rail_mv,
    input  wire logic [15:0]          input_supply_mv,
    input  wire logic [7:0]           die_temp_c,
    input  wire logic [6:0]           charge_current_pct,
    // Thermistor comparators, asynchronous
    input  wire logic                 thermistor_present,
    input  wire logic                 thermistor_cold,
    input  wire logic                 thermistor_hot,
    // Charge loop controls
    output lcp_pkg::lcp_phase_t       phase,
    output logic                      trickle_active,
    output logic      [5:0]           trickle_current_ma,
    output logic      [6:0]           charge_current_set_pct,
    output logic                      cv_regulate,
    output logic      [15:0]          termination_mv,
    output logic      [11:0]          input_current_limit_ma,
    output logic                      supplement_en,
    output logic                      die_fault_irq
);
    import lcp_pkg::*;

    localparam int SYNC_W = 16 + 16 + 16 + 8 + 7 + 3;

    // Three-stage synchroniser; a new sample counts once stages two and three agree
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] held;
    wire  [SYNC_W-1:0] raw_bus = {vbat_mv, system_rail_mv, input_supply_mv, die_temp_c,
                                  charge_current_pct, thermistor_present, thermistor_cold,
                                  thermistor_hot};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            held  <= '0;
        end else begin
            sync1 <= raw_bus;
            sync2 <= sync1;
            sync3 <= sync2;
            // Whole-word agreement keeps multi-bit samples from tearing
            if (sync2 == sync3) begin
                held <= sync3;
            end
        end
    end

    wire [15:0] s_vbat  = held[65:50];
    wire [15:0] s_system_rail  = held[49:34];
    wire [15:0] s_vin   = held[33:18];
    wire [7:0]  s_die   = held[17:10];
    wire [6:0]  s_fast_charge_current  = held[9:3];
    wire        s_pres  = held[2];
    wire        s_cold  = held[1];
    wire        s_hot   = held[0];

    // Software registers
    logic [2:0]  ctrl_reg;
    logic [10:0] thresh_reg;
    logic [9:0]  curr_reg;
    logic        bat_temp_status;
    logic        charge_fault;

    wire        charger_enable_bit       = ctrl_reg[`LCP_CTRL_EN];
    wire        thermal_foldback_disable = ctrl_reg[`LCP_CTRL_TFD];
    wire        trickle_current_sel      = ctrl_reg[`LCP_CTRL_TCS];
    wire [1:0]  trickle_threshold_sel    = thresh_reg[1:0];
    wire [3:0]  pre_threshold_sel        = thresh_reg[5:2];
    wire [4:0]  termination_voltage_sel  = thresh_reg[10:6];
    wire [1:0]  precondition_current_sel = curr_reg[1:0];
    wire [1:0]  termination_current_sel  = curr_reg[3:2];
    wire [1:0]  recharge_offset_sel      = curr_reg[5:4];
    wire [1:0]  input_voltage_threshold_sel = curr_reg[7:6];
    wire [1:0]  input_current_limit_sel  = curr_reg[9:8];

    // Threshold decode
    logic [15:0] trickle_mv;
    always_comb begin
        case (trickle_threshold_sel)
            2'h0:    trickle_mv = `LCP_TRICKLE_MV_0;
            2'h1:    trickle_mv = `LCP_TRICKLE_MV_1;
            2'h2:    trickle_mv = `LCP_TRICKLE_MV_2;
            default: trickle_mv = `LCP_TRICKLE_MV_3;
        endcase
    end

    wire [15:0] pre_mv  = `LCP_PRE_BASE_MV
                        + 16'(`LCP_PRE_STEP_MV * 16'(pre_threshold_sel));
    wire [15:0] term_mv = `LCP_TERM_BASE_MV
                        + 16'(`LCP_TERM_STEP_MV * 16'(termination_voltage_sel));
    wire [15:0] rechg_off_mv = `LCP_RECHG_BASE_MV
                        + 16'(`LCP_RECHG_STEP_MV * 16'(recharge_offset_sel));
    wire [15:0] recharge_level = term_mv - rechg_off_mv;
    wire [6:0]  pre_pct   = 7'(`LCP_PCT_STEP * 7'({1'b0, precondition_current_sel} + 3'h1));
    wire [6:0]  termination_current_sel_pct = 7'(`LCP_PCT_STEP * 7'({1'b0, termination_current_sel} + 3'h1));
    wire [5:0]  trickle_ma = trickle_current_sel ? `LCP_TRICKLE_MA_HI
                                                 : `LCP_TRICKLE_MA_LO;
    wire [11:0] ilim_ma = 12'(`LCP_ILIM_STEP_MA * 12'({1'b0, input_current_limit_sel} + 3'h1));

    logic [15:0] vin_thr_mv;
    always_comb begin
        case (input_voltage_threshold_sel)
            2'h1:    vin_thr_mv = `LCP_VIN_THR_MV_1;
            2'h2:    vin_thr_mv = `LCP_VIN_THR_MV_2;
            2'h3:    vin_thr_mv = `LCP_VIN_THR_MV_3;
            default: vin_thr_mv = 16'h0000;
        endcase
    end

    // Enable and condition flags
    wire auto_enable  = s_system_rail > (s_vbat + `LCP_ENABLE_MARGIN);
    wire enabled      = auto_enable && charger_enable_bit;
    wire die_fault    = s_die >= `LCP_DIE_FAULT_C;
    wire bat_suspend  = !s_pres || s_cold || s_hot;
    wire in_supplement = s_vin <= `LCP_VIN_SUPPL_MV;

    lcp_zone_t zone;
    assign zone = !s_pres ? LCP_ZONE_ABSENT :
                  s_cold  ? LCP_ZONE_COLD   :
                  s_hot   ? LCP_ZONE_HOT    : LCP_ZONE_NORMAL;

    // Entry phase chosen from the battery voltage alone
    lcp_phase_t entry_phase;
    assign entry_phase = (s_vbat < trickle_mv) ? LCP_TRICKLE :
                         (s_vbat <= pre_mv)    ? LCP_PRE     : LCP_FAST;

    // Phase machine; faults and suspension are checked ahead of voltage moves
    lcp_phase_t next_phase;
    always_comb begin
        next_phase = phase;
        if (!enabled) begin
            next_phase = LCP_OFF;
        end else if (die_fault) begin
            next_phase = LCP_FAULT;
        end else if (bat_suspend) begin
            next_phase = LCP_SUSPEND;
        end else begin
            case (phase)
                LCP_OFF, LCP_SUSPEND: begin
                    next_phase = entry_phase;
                end
                LCP_FAULT: begin
                    // Stay parked until the die is back below the zero-current point
                    if (s_die < `LCP_DIE_ZERO_C) begin
                        next_phase = entry_phase;
                    end
                end
                LCP_TRICKLE: begin
                    if (s_vbat > trickle_mv) begin
                        next_phase = LCP_PRE;
                    end
                end
                LCP_PRE: begin
                    if (s_vbat > pre_mv) begin
                        next_phase = LCP_FAST;
                    end else if (s_vbat < trickle_mv) begin
                        next_phase = LCP_TRICKLE;
                    end
                end
                LCP_FAST: begin
                    if (s_vbat >= term_mv) begin
                        next_phase = LCP_CV;
                    end
                end
                LCP_CV: begin
                    if (s_fast_charge_current < termination_current_sel_pct) begin
                        next_phase = LCP_EOC;
                    end
                end
                LCP_EOC: begin
                    if (s_vbat < recharge_level) begin
                        next_phase = LCP_FAST;
                    end
                end
                default: begin
                    next_phase = LCP_OFF;
                end
            endcase
        end
    end

    // Base current by phase, as a percentage of the fast-charge setting
    logic [6:0] base_pct;
    always_comb begin
        case (next_phase)
            LCP_PRE:          base_pct = pre_pct;
            LCP_FAST, LCP_CV: base_pct = `LCP_FULL_PCT;
            default:          base_pct = 7'h00;
        endcase
    end

    // Die foldback fraction of 256: linear from 115C down to zero at 150C
    wire [7:0]  die_left   = `LCP_DIE_ZERO_C - s_die;
    wire [18:0] therm_prod = 19'(die_left) * 19'(`LCP_THERM_GAIN);
    wire [8:0]  therm_frac = (thermal_foldback_disable || s_die < `LCP_DIE_FOLD_C)
                           ? `LCP_FRAC_ONE
                           : (s_die >= `LCP_DIE_ZERO_C) ? 9'h000
                           : 9'(therm_prod[16:8]);

    // Input droop fraction of 256: linear over the span below the threshold
    wire [15:0] vin_floor  = vin_thr_mv - `LCP_VIN_SPAN_MV;
    wire [15:0] vin_above  = s_vin - vin_floor;
    wire [16:0] vin_prod   = 17'(vin_above[9:0]) * 17'(`LCP_VIN_GAIN);
    wire        vin_off    = input_voltage_threshold_sel == 2'h0;
    wire [8:0]  vin_frac   = (vin_off || s_vin >= vin_thr_mv) ? `LCP_FRAC_ONE
                           : (s_vin <= vin_floor)            ? 9'h000
                           : 9'(vin_prod[16:8]);

    wire [8:0]  min_frac   = (therm_frac < vin_frac) ? therm_frac : vin_frac;
    wire [15:0] scaled     = 16'(base_pct) * 16'(min_frac);
    wire        next_suppl = enabled && in_supplement;
    wire [6:0]  next_pct   = next_suppl ? 7'h00 : scaled[14:8];

    // Output stage
    logic die_fault_d;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase                  <= LCP_OFF;
            trickle_active         <= 1'b0;
            trickle_current_ma     <= '0;
            charge_current_set_pct <= '0;
            cv_regulate            <= 1'b0;
            termination_mv         <= '0;
            input_current_limit_ma <= '0;
            supplement_en          <= 1'b0;
            die_fault_irq          <= 1'b0;
            die_fault_d            <= 1'b0;
        end else begin
            phase                  <= next_phase;
            trickle_active         <= (next_phase == LCP_TRICKLE) && !next_suppl;
            trickle_current_ma     <= trickle_ma;
            charge_current_set_pct <= next_pct;
            cv_regulate            <= next_phase == LCP_CV;
            termination_mv         <= term_mv;
            input_current_limit_ma <= ilim_ma;
            supplement_en          <= next_suppl;
            die_fault_d            <= die_fault;
            die_fault_irq          <= die_fault && !die_fault_d;
        end
    end

    // Register writes; the sticky flags are write-one-to-clear and a set wins
    wire wr_ctrl   = reg_wr && reg_addr == `LCP_REG_CTRL;
    wire wr_thresh = reg_wr && reg_addr == `LCP_REG_THRESH;
    wire wr_curr   = reg_wr && reg_addr == `LCP_REG_CURR;
    wire wr_status = reg_wr && reg_addr == `LCP_REG_STATUS;
    wire clr_bts   = wr_status && reg_wdata[`LCP_ST_BTS];
    wire clr_fault = wr_status && reg_wdata[`LCP_ST_FAULT];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg        <= `LCP_CTRL_RST;
            thresh_reg      <= `LCP_THRESH_RST;
            curr_reg        <= `LCP_CURR_RST;
            bat_temp_status <= 1'b0;
            charge_fault    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= reg_wdata[2:0];
            end
            if (wr_thresh) begin
                thresh_reg <= reg_wdata[10:0];
            end
            if (wr_curr) begin
                curr_reg <= reg_wdata[9:0];
            end
            bat_temp_status <= die_fault || (bat_temp_status && !clr_bts);
            charge_fault    <= die_fault || (charge_fault && !clr_fault);
        end
    end

    // Read data: one cycle after the strobe, zero otherwise and for unmapped words
    wire [31:0] status_word = {17'h00000, auto_enable, charge_fault, bat_temp_status,
                               zone, s_pres, supplement_en, phase};
    wire [31:0] levels_word = {term_mv, 9'h000, charge_current_set_pct};
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr)
            `LCP_REG_CTRL:   rd_mux = {29'h0, ctrl_reg};
            `LCP_REG_THRESH: rd_mux = {21'h0, thresh_reg};
            `LCP_REG_CURR:   rd_mux = {22'h0, curr_reg};
            `LCP_REG_STATUS: rd_mux = status_word;
            `LCP_REG_LEVELS: rd_mux = levels_word;
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

endmodule // lcp_charge_ctrl

// ===== lcp_charge_ctrl_properties.sv
`timescale 1ns/100ps
module lcp_charge_ctrl_properties (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    // Watched outputs
    input  wire lcp_pkg::lcp_phase_t phase,
    input  wire logic                trickle_active,
    input  wire logic [5:0]          trickle_current_ma,
    input  wire logic [6:0]          charge_current_set_pct,
    input  wire logic                cv_regulate,
    input  wire logic [15:0]         termination_mv,
    input  wire logic [11:0]         input_current_limit_ma,
    input  wire logic                supplement_en,
    input  wire logic                die_fault_irq
);
    import lcp_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Outputs register from next_phase in the same cycle as the phase; a settled phase is still required
    a_trickle_only: assert property (phase == LCP_TRICKLE && $past(phase) == LCP_TRICKLE
        |-> trickle_active && charge_current_set_pct == 7'h0) else $error("trickle output");
    // Register-derived outputs hold zero during reset, so skip the first edge after release
    a_trickle_ma: assert property ($past(nrst)
        |-> trickle_current_ma == 6'd10 || trickle_current_ma == 6'd25)
        else $error("trickle current value");
    a_cv_flag: assert property (phase == LCP_CV && $past(phase) == LCP_CV |-> cv_regulate)
        else $error("cv flag");
    a_term_grid: assert property ($past(nrst) |-> termination_mv >= 16'd3900
        && termination_mv <= 16'd4520
        && (termination_mv - 16'd3900) % 16'd20 == 16'h0) else $error("termination grid");
    a_eoc_zero: assert property (phase == LCP_EOC && $past(phase) == LCP_EOC
        |-> charge_current_set_pct == 7'h0) else $error("eoc current");
    a_supp_zero: assert property (supplement_en && $past(supplement_en)
        |-> charge_current_set_pct == 7'h0) else $error("supplement current");
    a_ilim_set: assert property ($past(nrst) |-> input_current_limit_ma inside {12'd500,
        12'd1000, 12'd1500, 12'd2000}) else $error("input limit value");
    a_irq_pulse: assert property ($rose(die_fault_irq) |=> !die_fault_irq [*2])
        else $error("irq pulse length");
    a_fault_zero: assert property (phase == LCP_FAULT && $past(phase) == LCP_FAULT
        |-> charge_current_set_pct == 7'h0 && !trickle_active) else $error("fault current");
    a_phase_hot: assert property ($onehot(phase)) else $error("phase encoding");
endmodule // lcp_charge_ctrl_properties

bind lcp_charge_ctrl lcp_charge_ctrl_properties u_props (
    .clk_sys(clk_sys), .nrst(nrst), .phase(phase), .trickle_active(trickle_active),
    .trickle_current_ma(trickle_current_ma), .charge_current_set_pct(charge_current_set_pct),
    .cv_regulate(cv_regulate), .termination_mv(termination_mv),
    .input_current_limit_ma(input_current_limit_ma), .supplement_en(supplement_en),
    .die_fault_irq(die_fault_irq));

// ===== lcp_consts.svh
`ifndef LCP_CONSTS_SVH
`define LCP_CONSTS_SVH
// Register word indices
`define LCP_REG_CTRL        4'h0
`define LCP_REG_THRESH      4'h1
`define LCP_REG_CURR        4'h2
`define LCP_REG_STATUS      4'h3
`define LCP_REG_LEVELS      4'h4
// Field positions
`define LCP_CTRL_EN         0
`define LCP_CTRL_TFD        1
`define LCP_CTRL_TCS        2
`define LCP_ST_SUPPL        8
`define LCP_ST_PRESENT      9
`define LCP_ST_ZONE         10
`define LCP_ST_BTS          12
`define LCP_ST_FAULT        13
`define LCP_ST_AUTO         14
// Reset values
`define LCP_CTRL_RST        3'h1
`define LCP_THRESH_RST      11'h3d8
`define LCP_CURR_RST        10'h040
// Voltage figures in mV
`define LCP_TRICKLE_MV_0    16'd2000
`define LCP_TRICKLE_MV_1    16'd2200
`define LCP_TRICKLE_MV_2    16'd2400
`define LCP_TRICKLE_MV_3    16'd2500
`define LCP_PRE_BASE_MV     16'd2700
`define LCP_PRE_STEP_MV     16'd50
`define LCP_TERM_BASE_MV    16'd3900
`define LCP_TERM_STEP_MV    16'd20
`define LCP_RECHG_BASE_MV   16'd80
`define LCP_RECHG_STEP_MV   16'd40
`define LCP_VIN_THR_MV_1    16'd4250
`define LCP_VIN_THR_MV_2    16'd4500
`define LCP_VIN_THR_MV_3    16'd4750
`define LCP_VIN_SPAN_MV     16'd700
`define LCP_VIN_SUPPL_MV    16'd3800
`define LCP_ENABLE_MARGIN   16'd100
// Currents
`define LCP_TRICKLE_MA_LO   6'd10
`define LCP_TRICKLE_MA_HI   6'd25
`define LCP_ILIM_STEP_MA    12'd500
`define LCP_PCT_STEP        7'd5
`define LCP_FULL_PCT        7'd100
// Die temperature in degrees C
`define LCP_DIE_FOLD_C      8'd115
`define LCP_DIE_ZERO_C      8'd150
`define LCP_DIE_FAULT_C     8'd155
// Fractions of 256 for the linear foldbacks
`define LCP_FRAC_ONE        9'd256
`define LCP_THERM_GAIN      11'd1872
`define LCP_VIN_GAIN        7'd94
`endif

// ===== lcp_pkg.sv
package lcp_pkg;
    typedef enum logic [7:0] {
        LCP_OFF     = 8'h01,
        LCP_TRICKLE = 8'h02,
        LCP_PRE     = 8'h04,
        LCP_FAST    = 8'h08,
        LCP_CV      = 8'h10,
        LCP_EOC     = 8'h20,
        LCP_SUSPEND = 8'h40,
        LCP_FAULT   = 8'h80
    } lcp_phase_t;
    typedef enum logic [1:0] {
        LCP_ZONE_ABSENT = 2'h0,
        LCP_ZONE_COLD   = 2'h1,
        LCP_ZONE_NORMAL = 2'h2,
        LCP_ZONE_HOT    = 2'h3
    } lcp_zone_t;
endpackage

// ===== lcp_tb.sv
`timescale 1ns/100ps
module testbench;
    import lcp_pkg::*;
    logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, rd_seen = 0;
    logic [3:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, exp_q[$], mask_q[$], x = 32'd37560;
    logic [15:0] vb = 1000, vs = 4800, vi = 5000, vbat_mv, system_rail_mv, input_supply_mv;
    logic [15:0] termination_mv, thr;
    logic [7:0] dt = 25, die_temp_c;
    logic [6:0] tp = 0, charge_current_pct, charge_current_set_pct;
    logic tpres = 1, tcold = 0, thot = 0, trickle_active, cv_regulate, supplement_en, irq;
    logic [5:0] trickle_current_ma;
    logic [11:0] input_current_limit_ma;
    lcp_phase_t phase;
    int failures = 0, n_checks = 0, n_irq = 0;
    always #2 clk_sys = ~clk_sys;
    lcp_batt_model u_batt (.cmd_vbat(vb), .cmd_system_rail(vs), .cmd_vin(vi), .cmd_die(dt),
        .cmd_taper(tp), .cv_regulate(cv_regulate), .charge_current_set_pct(charge_current_set_pct),
        .vbat_mv(vbat_mv), .system_rail_mv(system_rail_mv), .input_supply_mv(input_supply_mv),
        .die_temp_c(die_temp_c), .charge_current_pct(charge_current_pct));
    lcp_charge_ctrl u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .vbat_mv(vbat_mv), .system_rail_mv(system_rail_mv), .input_supply_mv(input_supply_mv),
        .die_temp_c(die_temp_c), .charge_current_pct(charge_current_pct),
        .thermistor_present(tpres), .thermistor_cold(tcold), .thermistor_hot(thot),
        .phase(phase), .trickle_active(trickle_active), .trickle_current_ma(trickle_current_ma),
        .charge_current_set_pct(charge_current_set_pct), .cv_regulate(cv_regulate),
        .termination_mv(termination_mv), .input_current_limit_ma(input_current_limit_ma),
        .supplement_en(supplement_en), .die_fault_irq(irq));
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_sys);
        reg_rd <= 1; reg_addr <= a;
        exp_q.push_back(e & m); mask_q.push_back(m);
        @(posedge clk_sys);
        reg_rd <= 0;
    endtask
    // Synchroniser plus phase update need five edges; ten leaves margin
    task automatic settle();
        repeat (10) @(posedge clk_sys);
        #1;
    endtask
    task automatic ph(input lcp_phase_t p);
        rd(4'h3, {24'h0, p}, 32'hff);
    endtask
    task automatic reset_dut();
        @(posedge clk_sys); nrst <= 0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1;
        settle();
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys) rd_seen <= reg_rd;
    always @(negedge clk_sys) if (rd_seen) chk("reg_rdata", exp_q.pop_front(), reg_rdata & mask_q.pop_front());
    always @(posedge clk_sys) if (irq === 1'b1) n_irq++;
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
    initial begin
        reset_dut();
        rd(4'h0, 32'h1, 32'h7); rd(4'h1, 32'h3d8, 32'h7ff); rd(4'h2, 32'h40, 32'h3ff);
        wr(4'h5, 32'hffff); rd(4'h5, 32'h0, 32'hffffffff);
        chk("trickle_ma", 10, trickle_current_ma);
        for (int k = 0; k < 4; k++) begin
            thr = (k == 0) ? 16'd2000 : (k == 1) ? 16'd2200 : (k == 2) ? 16'd2400 : 16'd2500;
            vb <= 1000; reset_dut(); wr(4'h1, 32'h3d8 | k);
            vb <= thr - 16'd1 - 16'(rnd() % 300); settle();
            ph(LCP_TRICKLE);
            chk("trickle_active", 1, trickle_active);
            vb <= thr + 16'd5; settle(); ph(LCP_PRE);
        end
        wr(4'h0, 32'h5); settle(); chk("trickle_ma", 25, trickle_current_ma);
        for (int k = 0; k < 4; k++) begin
            wr(4'h2, 32'h40 | k); settle(); rd(4'h4, 5 * (k + 1), 32'h7f);
        end
        wr(4'h0, 32'h1); wr(4'h1, 32'h3eb); vb <= 3195; settle(); ph(LCP_PRE);
        vb <= 3205; settle(); ph(LCP_FAST); rd(4'h4, 100, 32'h7f);
        // Indices run downwards, so code 15 (4200 mV) is left in place for what follows
        foreach (thr[i]) if (i < 3) begin
            wr(4'h1, 32'h2b | (((i == 0) ? 15 : (i == 1) ? 31 : 0) << 6)); settle();
            chk("term_mv", 3900 + 20 * ((i == 0) ? 15 : (i == 1) ? 31 : 0), termination_mv);
        end
        rd(4'h4, 32'd4200 << 16, 32'hffff0000);
        for (int k = 0; k < 4; k++) begin
            wr(4'h2, 32'h40 | (k << 2) | (k << 4)); tp <= 5 * (k + 1) + 1;
            vb <= 4202; settle(); ph(LCP_CV); chk("cv", 1, cv_regulate);
            tp <= 5 * (k + 1) - 1; settle(); ph(LCP_EOC);
            rd(4'h4, 0, 32'h7f);
            vb <= 4200 - (80 + 40 * k) + 5; settle(); ph(LCP_EOC);
            vb <= 4200 - (80 + 40 * k) - 5; settle(); ph(LCP_FAST);
        end
        wr(4'h2, 32'h40); vi <= 4000; settle();
        chk("vin_fold", 1, charge_current_set_pct > 0 && charge_current_set_pct < 100);
        vi <= 3800; settle(); chk("supplement", 1, supplement_en);
        rd(4'h3, 32'h100, 32'h100); rd(4'h4, 0, 32'h7f);
        vi <= 4000; wr(4'h2, 32'h0); settle(); rd(4'h4, 100, 32'h7f);
        vi <= 5000;
        for (int k = 0; k < 4; k++) begin
            wr(4'h2, k << 8); settle(); chk("ilim", 500 * (k + 1), input_current_limit_ma);
        end
        wr(4'h2, 32'h40); dt <= 130; settle();
        chk("die_fold", 1, charge_current_set_pct > 0 && charge_current_set_pct < 100);
        dt <= 150; settle(); rd(4'h4, 0, 32'h7f);
        wr(4'h0, 32'h3); dt <= 130; settle(); rd(4'h4, 100, 32'h7f);
        wr(4'h0, 32'h1); dt <= 155; settle(); chk("irq_count", 1, n_irq);
        rd(4'h3, 32'h3080, 32'h30ff);
        dt <= 25; settle(); wr(4'h3, 32'h3000); settle();
        rd(4'h3, 32'h0, 32'h3000); ph(LCP_FAST);
        tpres <= 0; settle(); rd(4'h3, 32'h40, 32'hfff);
        tpres <= 1; tcold <= 1; settle(); rd(4'h3, 32'h640, 32'hfff);
        tcold <= 0; thot <= 1; settle(); rd(4'h3, 32'he40, 32'hfff);
        thot <= 0; settle(); rd(4'h3, 32'ha00, 32'hf00);
        vs <= vb + 50; settle(); rd(4'h3, 32'h1, 32'h40ff);
        vs <= 4800; settle(); rd(4'h3, 32'h4000, 32'h4000);
        wr(4'h0, 32'h0); settle(); ph(LCP_OFF);
        settle();
        report_and_stop();
    end
endmodule // testbench
